/* hw/spi_boot_pkg.sv */
package spi_boot_pkg;
   // ********************************
   // instruction codes
   // ********************************
   localparam logic [7:0] OP_WRITE_REGS = 8'h01;
   localparam logic [7:0] OP_CLEAR_WRITE_ENABLE = 8'h04;
   localparam logic [7:0] OP_SET_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_BOOT_REG_READ = 8'h14;
   localparam logic [7:0] OP_BOOT_REG_WRITE = 8'h15;
   localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
   localparam logic [7:0] OP_BANK_ACCESS = 8'hB9;

   // ********************************
   // register fields and reset values
   // ********************************
   localparam int SR_WRITE_IN_PROGRESS = 0;
   localparam int SR_WRITE_ENABLE_LATCH = 1;
   localparam int SR_ERASE_FAIL = 5;
   localparam int SR_PROGRAM_FAIL = 6;
   localparam int SR_STATUS_WRITE_DISABLE = 7;
   localparam int CR_QUAD_ENABLE = 1;
   localparam int BOOT_ENABLE_BIT = 0;
   localparam int BOOT_DELAY_LO = 1;
   localparam int BOOT_ADDR_LO = 9;
   localparam logic [7:0] SR1_RESET = 8'h00;
   localparam logic [7:0] CR1_RESET = 8'h00;
   localparam logic [7:0] SR2_RESET = 8'h00;
   localparam logic [7:0] BANK_RESET = 8'h00;
   localparam logic [31:0] BOOT_REG_RESET = 32'h00000000;

   // ********************************
   // bit counts and timing
   // ********************************
   localparam logic [5:0] INSTR_BITS = 6'h08;
   localparam logic [5:0] BOOT_WRITE_BITS = 6'h28;
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int REG_UPDATE_NS = 2000;
   localparam int REG_UPDATE_CYCLES = (REG_UPDATE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int SCK_HALF_NS = 60;
   localparam int SCK_HALF_CYCLES = (SCK_HALF_NS / CLOCK_PERIOD_NS < 1) ? 1 :
      SCK_HALF_NS / CLOCK_PERIOD_NS;

   // the boot register travels least significant byte first
   function automatic logic [31:0] byte_swap(input logic [31:0] v);
      byte_swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction
endpackage

/* hw/spi_boot_if.sv */
`timescale 1ns/1ps
interface spi_boot_if;
   logic cs_n;
   logic sck;
   logic [3:0] host_io;
   logic [3:0] host_io_oe_n;
   logic [3:0] dev_io;
   logic [3:0] dev_io_oe_n;
   logic [3:0] io;

   // undriven lines float high, as with the usual pull-ups; io2 doubles as write protect
   assign io = (~host_io_oe_n & host_io) | (host_io_oe_n & ~dev_io_oe_n & dev_io) |
      (host_io_oe_n & dev_io_oe_n);

   modport host (output cs_n, output sck, output host_io, output host_io_oe_n, input io);
   modport device (input cs_n, input sck, output dev_io, output dev_io_oe_n, input io);
endinterface

/* hw/spi_boot_device.sv */
`timescale 1ns/1ps
module spi_boot_device #(
   parameter logic [31:0] boot_init = spi_boot_pkg::BOOT_REG_RESET
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // serial link
   spi_boot_if.device link,
   // array read port, data valid one clock after the address
   output logic [31:0] mem_addr,
   input wire logic [7:0] mem_data,
   // update outcome, sampled as the boot register update ends
   input wire logic erase_fail,
   input wire logic program_fail,
   // register view
   output logic [7:0] first_status_register,
   output logic [7:0] first_config_register,
   output logic [7:0] second_status_register,
   output logic [7:0] bank_register,
   output logic [31:0] boot_read_configuration
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD = 2'b01,
      ST_REG_OUT = 2'b10,
      ST_BOOT = 2'b11
   } dev_state_t;

   typedef struct packed {
      logic cs_meta;
      logic cs_sync;
      logic cs_prev;
      logic sck_meta;
      logic sck_sync;
      logic sck_prev;
      logic [3:0] io_meta;
      logic [3:0] io_sync;
      dev_state_t st;
      logic [5:0] bits;
      logic [7:0] opcode;
      logic [31:0] shin;
      logic [31:0] out_sh;
      logic [7:0] bsh;
      logic [3:0] bcnt;
      logic [7:0] dly;
      logic [31:0] addr;
      logic [7:0] sr1;
      logic [7:0] cr1;
      logic [7:0] sr2;
      logic [7:0] bank;
      logic [31:0] boot_reg;
      logic [31:0] boot_new;
      logic boot_pending;
      logic bank_armed;
      logic boot_update;
      logic [15:0] busy_cnt;
      logic [3:0] io_o;
      logic [3:0] io_oe_n;
   } dev_regs_t;

   dev_regs_t q;
   dev_regs_t next_q;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic quad;
   logic hw_locked;
   logic boot_on;
   logic [7:0] boot_dly;
   logic [7:0] wr_first;
   logic boot_emit;

   assign cs_fall = q.cs_prev & ~q.cs_sync;
   assign cs_rise = ~q.cs_prev & q.cs_sync;
   assign sck_rise = ~q.cs_sync & ~q.sck_prev & q.sck_sync;
   assign sck_fall = ~q.cs_sync & q.sck_prev & ~q.sck_sync;
   assign quad = q.cr1[spi_boot_pkg::CR_QUAD_ENABLE];
   assign hw_locked = q.sr1[spi_boot_pkg::SR_STATUS_WRITE_DISABLE] & ~q.io_sync[2] & ~quad;
   assign boot_on = q.boot_reg[spi_boot_pkg::BOOT_ENABLE_BIT];
   assign boot_dly = q.boot_reg[spi_boot_pkg::BOOT_DELAY_LO +: 8];
   // first data byte of a write registers command, wherever the count left it
   assign wr_first = (q.bits == 6'h10) ? q.shin[7:0] :
      (q.bits == 6'h18) ? q.shin[15:8] : q.shin[23:16];
   assign boot_emit = (cs_fall & q.boot_pending & boot_on & (boot_dly == 8'h00)) |
      ((q.st == ST_BOOT) & sck_fall & (q.dly <= 8'h01));

   // ********************************
   // next state
   // ********************************
   always_comb begin
      next_q = q;
      next_q.cs_meta = link.cs_n;
      next_q.cs_sync = q.cs_meta;
      next_q.cs_prev = q.cs_sync;
      next_q.sck_meta = link.sck;
      next_q.sck_sync = q.sck_meta;
      next_q.sck_prev = q.sck_sync;
      next_q.io_meta = link.io;
      next_q.io_sync = q.io_meta;

      if (q.busy_cnt != 16'h0000) begin
         next_q.busy_cnt = q.busy_cnt - 16'h0001;
         if (q.busy_cnt == 16'h0001) begin
            next_q.sr1[spi_boot_pkg::SR_WRITE_IN_PROGRESS] = 1'b0;
            next_q.sr1[spi_boot_pkg::SR_WRITE_ENABLE_LATCH] = 1'b0;
            next_q.boot_update = 1'b0;
            if (q.boot_update) begin
               if (erase_fail) begin
                  next_q.sr1[spi_boot_pkg::SR_ERASE_FAIL] = 1'b1;
               end else if (program_fail) begin
                  next_q.sr1[spi_boot_pkg::SR_PROGRAM_FAIL] = 1'b1;
               end else begin
                  next_q.boot_reg = q.boot_new;
               end
            end
         end
      end

      if (q.boot_pending && q.st != ST_BOOT) begin
         next_q.addr = {q.boot_reg[31:spi_boot_pkg::BOOT_ADDR_LO], 9'h000};
      end

      if (cs_fall) begin
         next_q.bits = 6'h00;
         next_q.bcnt = 4'h0;
         next_q.dly = boot_dly;
         if (q.boot_pending && boot_on) begin
            next_q.st = ST_BOOT;
         end else begin
            next_q.st = ST_CMD;
            next_q.boot_pending = 1'b0;
         end
      end

      if (sck_rise && q.st == ST_CMD) begin
         next_q.shin = {q.shin[30:0], q.io_sync[0]};
         next_q.bits = (q.bits == 6'h3F) ? q.bits : q.bits + 6'h01;
         if (q.bits == spi_boot_pkg::INSTR_BITS - 6'h01) begin
            next_q.opcode = {q.shin[6:0], q.io_sync[0]};
            if ({q.shin[6:0], q.io_sync[0]} == spi_boot_pkg::OP_BOOT_REG_READ) begin
               next_q.st = ST_REG_OUT;
               next_q.out_sh = spi_boot_pkg::byte_swap(q.boot_reg);
            end
         end
      end

      if (sck_fall && q.st == ST_REG_OUT) begin
         next_q.io_o = {2'b00, q.out_sh[31], 1'b0};
         next_q.io_oe_n = 4'b1101;
         next_q.out_sh = {q.out_sh[30:0], q.out_sh[31]};
      end

      if (sck_fall && q.st == ST_BOOT && q.dly > 8'h01) begin
         next_q.dly = q.dly - 8'h01;
      end

      if (boot_emit) begin
         next_q.dly = 8'h00;
         if (q.bcnt == 4'h0) begin
            next_q.bsh = mem_data;
            next_q.bcnt = 4'h8;
            next_q.addr = next_q.addr + 32'h00000001;
         end else begin
            next_q.bsh = q.bsh;
            next_q.bcnt = q.bcnt;
         end
         if (quad) begin
            next_q.io_o = next_q.bsh[7:4];
            next_q.io_oe_n = 4'b0000;
            next_q.bsh = {next_q.bsh[3:0], 4'h0};
            next_q.bcnt = next_q.bcnt - 4'h4;
         end else begin
            next_q.io_o = {2'b00, next_q.bsh[7], 1'b0};
            next_q.io_oe_n = 4'b1101;
            next_q.bsh = {next_q.bsh[6:0], 1'b0};
            next_q.bcnt = next_q.bcnt - 4'h1;
         end
      end

      if (cs_rise) begin
         next_q.st = ST_IDLE;
         next_q.io_oe_n = 4'b1111;
         next_q.bank_armed = 1'b0;
         if (q.st == ST_BOOT) begin
            next_q.boot_pending = 1'b0;
         end
         if (q.st == ST_CMD) begin
            case (q.opcode)
               spi_boot_pkg::OP_SET_WRITE_ENABLE: begin
                  if (q.bits == spi_boot_pkg::INSTR_BITS) begin
                     next_q.sr1[spi_boot_pkg::SR_WRITE_ENABLE_LATCH] = 1'b1;
                  end
               end
               spi_boot_pkg::OP_CLEAR_WRITE_ENABLE: begin
                  if (q.bits == spi_boot_pkg::INSTR_BITS &&
                      !q.sr1[spi_boot_pkg::SR_WRITE_IN_PROGRESS]) begin
                     next_q.sr1[spi_boot_pkg::SR_WRITE_ENABLE_LATCH] = 1'b0;
                  end
               end
               spi_boot_pkg::OP_CLEAR_STATUS: begin
                  if (q.bits == spi_boot_pkg::INSTR_BITS) begin
                     next_q.sr1[spi_boot_pkg::SR_ERASE_FAIL] = 1'b0;
                     next_q.sr1[spi_boot_pkg::SR_PROGRAM_FAIL] = 1'b0;
                  end
               end
               spi_boot_pkg::OP_BANK_ACCESS: begin
                  if (q.bits == spi_boot_pkg::INSTR_BITS) begin
                     next_q.bank_armed = 1'b1;
                  end
               end
               spi_boot_pkg::OP_WRITE_REGS: begin
                  if (q.bits == 6'h10 || q.bits == 6'h18 || q.bits == 6'h20) begin
                     if (q.bank_armed) begin
                        if (q.sr1[6:5] == 2'b00 && !q.sr1[spi_boot_pkg::SR_WRITE_IN_PROGRESS]) begin
                           next_q.bank[1:0] = wr_first[1:0];
                        end
                     end else if (q.sr1[spi_boot_pkg::SR_WRITE_ENABLE_LATCH] && !hw_locked &&
                                  !q.sr1[spi_boot_pkg::SR_WRITE_IN_PROGRESS] &&
                                  !(quad && q.bits == 6'h10)) begin
                        next_q.sr1 = {wr_first[7], q.sr1[6:5], wr_first[4:2], 2'b11};
                        if (q.bits != 6'h10) begin
                           next_q.cr1 = (q.bits == 6'h18) ? q.shin[7:0] : q.shin[15:8];
                        end
                        if (q.bits == 6'h20) begin
                           next_q.sr2 = q.shin[7:0];
                        end
                        next_q.busy_cnt = 16'(spi_boot_pkg::REG_UPDATE_CYCLES);
                     end
                  end
               end
               spi_boot_pkg::OP_BOOT_REG_WRITE: begin
                  if (q.bits == spi_boot_pkg::BOOT_WRITE_BITS &&
                      q.sr1[spi_boot_pkg::SR_WRITE_ENABLE_LATCH] &&
                      !q.sr1[spi_boot_pkg::SR_WRITE_IN_PROGRESS]) begin
                     next_q.boot_new = spi_boot_pkg::byte_swap(q.shin);
                     next_q.boot_update = 1'b1;
                     next_q.sr1[spi_boot_pkg::SR_WRITE_IN_PROGRESS] = 1'b1;
                     next_q.busy_cnt = 16'(spi_boot_pkg::REG_UPDATE_CYCLES);
                  end
               end
               default: begin
                  next_q.bank_armed = 1'b0;
               end
            endcase
         end
      end
   end

   // ********************************
   // state register
   // ********************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.cs_meta <= 1'b1;
         q.cs_sync <= 1'b1;
         q.cs_prev <= 1'b1;
         q.sr1 <= spi_boot_pkg::SR1_RESET;
         q.cr1 <= spi_boot_pkg::CR1_RESET;
         q.sr2 <= spi_boot_pkg::SR2_RESET;
         q.bank <= spi_boot_pkg::BANK_RESET;
         q.boot_reg <= boot_init;
         q.boot_pending <= 1'b1;
         q.io_oe_n <= 4'b1111;
      end else begin
         q <= next_q;
      end
   end

   assign link.dev_io = q.io_o;
   assign link.dev_io_oe_n = q.io_oe_n;
   assign mem_addr = q.addr;
   assign first_status_register = q.sr1;
   assign first_config_register = q.cr1;
   assign second_status_register = q.sr2;
   assign bank_register = q.bank;
   assign boot_read_configuration = q.boot_reg;
endmodule

/* hw/spi_boot_host.sv */
`timescale 1ns/1ps
module spi_boot_host (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // serial link
   spi_boot_if.host link,
   // transfer request
   input wire logic cmd_valid,
   input wire logic [5:0] cmd_tx_bits,
   input wire logic [39:0] cmd_tx_data,
   input wire logic [6:0] cmd_rx_cycles,
   input wire logic cmd_rx_quad,
   input wire logic write_protect_level,
   // transfer result
   output logic cmd_ready,
   output logic cmd_done,
   output logic [63:0] rx_data
);
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LEAD = 3'b001,
      H_LOW = 3'b010,
      H_HIGH = 3'b011,
      H_TAIL = 3'b100
   } host_state_t;

   typedef struct packed {
      host_state_t st;
      logic [7:0] div;
      logic [7:0] idx;
      logic [7:0] total;
      logic [5:0] tx_bits;
      logic [39:0] tx_sh;
      logic rx_quad;
      logic [63:0] rx;
      logic [3:0] io_meta;
      logic [3:0] io_sync;
      logic cs_n;
      logic sck;
      logic [3:0] io_o;
      logic [3:0] io_oe_n;
      logic ready;
      logic done;
   } host_regs_t;

   localparam logic [7:0] HALF = 8'(spi_boot_pkg::SCK_HALF_CYCLES);

   host_regs_t q;
   host_regs_t next_q;
   logic tick;

   assign tick = (q.div == HALF - 8'h01);

   // ********************************
   // next state
   // ********************************
   always_comb begin
      next_q = q;
      next_q.io_meta = link.io;
      next_q.io_sync = q.io_meta;
      next_q.done = 1'b0;
      next_q.div = tick ? 8'h00 : q.div + 8'h01;
      // io2 carries write protect except through whole frames that return quad data
      next_q.io_o[2] = write_protect_level;
      case (q.st)
         H_IDLE: begin
            next_q.div = 8'h00;
            if (cmd_valid) begin
               next_q.st = H_LEAD;
               next_q.ready = 1'b0;
               next_q.cs_n = 1'b0;
               next_q.idx = 8'h00;
               next_q.tx_bits = cmd_tx_bits;
               next_q.total = {2'b00, cmd_tx_bits} + {1'b0, cmd_rx_cycles};
               next_q.tx_sh = cmd_tx_data;
               next_q.rx_quad = cmd_rx_quad;
               next_q.rx = 64'h0000000000000000;
               // serial frames keep io1 free for the device's answer, io2 driven as protect
               next_q.io_oe_n = cmd_rx_quad ? 4'b1111 : 4'b1010;
            end
         end
         H_LEAD, H_HIGH: begin
            if (tick) begin
               next_q.sck = 1'b0;
               if (q.idx == q.total) begin
                  next_q.st = H_TAIL;
               end else begin
                  next_q.st = H_LOW;
                  // bits leave on the falling side so the device samples mid-bit
                  if (q.idx < {2'b00, q.tx_bits}) begin
                     next_q.io_o[0] = q.tx_sh[39];
                     next_q.io_oe_n[0] = 1'b0;
                     next_q.tx_sh = {q.tx_sh[38:0], 1'b0};
                  end else begin
                     next_q.io_oe_n[0] = 1'b1;
                  end
               end
            end
         end
         H_LOW: begin
            if (tick) begin
               next_q.sck = 1'b1;
               next_q.st = H_HIGH;
               next_q.idx = q.idx + 8'h01;
               if (q.idx >= {2'b00, q.tx_bits}) begin
                  next_q.rx = q.rx_quad ? {q.rx[59:0], q.io_sync} : {q.rx[62:0], q.io_sync[1]};
               end
            end
         end
         H_TAIL: begin
            if (tick) begin
               next_q.cs_n = 1'b1;
               next_q.st = H_IDLE;
               next_q.ready = 1'b1;
               next_q.done = 1'b1;
               next_q.io_oe_n = 4'b1010;
               next_q.io_o[3] = 1'b1;
            end
         end
         default: begin
            next_q.st = H_IDLE;
         end
      endcase
   end

   // ********************************
   // state register
   // ********************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.cs_n <= 1'b1;
         q.io_o <= 4'b1000;
         q.io_oe_n <= 4'b1010;
         q.ready <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign link.cs_n = q.cs_n;
   assign link.sck = q.sck;
   assign link.host_io = q.io_o;
   assign link.host_io_oe_n = q.io_oe_n;
   assign cmd_ready = q.ready;
   assign cmd_done = q.done;
   assign rx_data = q.rx;
endmodule

/* sim/spi_boot_checker.sv */
`timescale 1ns/1ps
module spi_boot_checker (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // serial link
   input wire logic cs_n,
   input wire logic sck,
   input wire logic [3:0] dev_io_oe_n,
   // register view
   input wire logic [7:0] first_status_register,
   input wire logic [7:0] bank_register,
   input wire logic [31:0] boot_read_configuration
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   // ********************************
   // link framing
   // ********************************
   a_sck_in_frame: assert property (sck |-> !cs_n) else $error("sck high outside a frame");
   a_sck_half_period: assert property ($rose(sck) |-> sck[*6] ##1 !sck)
      else $error("sck high phase not six clocks");
   a_device_quiet: assert property (cs_n[*8] |-> dev_io_oe_n == 4'hF)
      else $error("device drives io while deselected");

   // ********************************
   // register updates
   // ********************************
   a_busy_holds: assert property ($rose(first_status_register[0]) |=> first_status_register[0][*8])
      else $error("busy dropped too early");
   a_busy_bounded: assert property ($rose(first_status_register[0]) |-> ##[150:260] !first_status_register[0])
      else $error("busy never ended");
   a_latch_cleared_end: assert property ($fell(first_status_register[0]) |-> !first_status_register[1])
      else $error("latch still set after update");
   a_latch_set_cs: assert property ($rose(first_status_register[1]) |-> cs_n)
      else $error("latch set inside a frame");
   a_fail_at_end: assert property ($rose(first_status_register[5]) || $rose(first_status_register[6]) |-> $past(first_status_register[0]))
      else $error("fail flag set outside an update");
   a_boot_reg_update: assert property ($changed(boot_read_configuration) |-> $past(first_status_register[0]))
      else $error("boot register changed without update");
   a_bank_low_only: assert property (bank_register[7:2] == 6'h00)
      else $error("bank upper bits changed");

   cover property ($rose(first_status_register[0]));
   cover property ($changed(bank_register));
   cover property (!cs_n && dev_io_oe_n != 4'hF);
endmodule

/* sim/test_spi_boot.sv */
`timescale 1ns/1ps
module test_spi_boot;
   localparam logic [31:0] BOOT_INIT = 32'h00000601;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0;
   logic [5:0] cmd_tx_bits = 6'h00;
   logic [39:0] cmd_tx_data = 40'h0000000000;
   logic [6:0] cmd_rx_cycles = 7'h00;
   logic cmd_rx_quad = 1'b0;
   logic write_protect_level = 1'b1;
   logic erase_fail = 1'b0;
   logic program_fail = 1'b0;
   logic [7:0] mem_data = 8'h00;
   logic cmd_ready, cmd_done;
   logic [63:0] rx_data;
   logic [31:0] mem_addr, boot_cfg, v2, sw;
   logic [7:0] sr1, cr1, sr2, bank;
   logic [63:0] exp_q[$], msk_q[$];
   int mismatches = 0;
   int checked = 0;
   int cycles = 0;

   spi_boot_if link_inst ();
   spi_boot_device #(.boot_init(BOOT_INIT)) spi_boot_device_inst (.clock(clock), .resetn(resetn),
      .link(link_inst.device), .mem_addr(mem_addr), .mem_data(mem_data), .erase_fail(erase_fail),
      .program_fail(program_fail), .first_status_register(sr1), .first_config_register(cr1),
      .second_status_register(sr2), .bank_register(bank), .boot_read_configuration(boot_cfg));
   spi_boot_host spi_boot_host_inst (.clock(clock), .resetn(resetn), .link(link_inst.host),
      .cmd_valid(cmd_valid), .cmd_tx_bits(cmd_tx_bits), .cmd_tx_data(cmd_tx_data),
      .cmd_rx_cycles(cmd_rx_cycles), .cmd_rx_quad(cmd_rx_quad),
      .write_protect_level(write_protect_level), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
      .rx_data(rx_data));
   spi_boot_checker spi_boot_checker_inst (.clock(clock), .resetn(resetn), .cs_n(link_inst.cs_n),
      .sck(link_inst.sck), .dev_io_oe_n(link_inst.dev_io_oe_n), .first_status_register(sr1),
      .bank_register(bank), .boot_read_configuration(boot_cfg));

   initial begin
      forever #5 clock = ~clock;
   end

   // array contents: one clock after the address, as the device expects
   always @(posedge clock) begin
      mem_data <= mem_addr[7:0] ^ 8'h5A;
   end

   // ********************************
   // checking
   // ********************************
   task automatic tally_and_finish();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t register %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_rx(input logic [63:0] got, input logic [63:0] exp, input logic [63:0] m);
      checked++;
      if ((got & m) !== (exp & m)) begin
         mismatches++;
         $display("MISMATCH %0t received %h expected %h", $time, got & m, exp & m);
      end
   endtask

   // oldest note is matched against every completed transfer
   always @(negedge clock) begin
      if (cmd_done === 1'b1) begin
         if (exp_q.size() == 0)
            check_rx(rx_data, 64'h0, 64'h0);
         else
            check_rx(rx_data, exp_q.pop_front(), msk_q.pop_front());
      end
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // ********************************
   // host requests
   // ********************************
   task automatic xfer(input logic [5:0] nb, input logic [39:0] d, input logic [6:0] rc,
         input logic [63:0] exp, input logic [63:0] m);
      int n;
      exp_q.push_back(exp);
      msk_q.push_back(m);
      @(negedge clock);
      cmd_tx_bits = nb;
      cmd_tx_data = d;
      cmd_rx_cycles = rc;
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
      n = 0;
      while (cmd_done !== 1'b1 && n < 3000) begin
         @(negedge clock);
         n++;
      end
      repeat (8) @(negedge clock);
   endtask

   task automatic op(input logic [7:0] c);
      xfer(6'h08, {c, 32'h00000000}, 7'h00, 64'h0, 64'h0);
   endtask

   task automatic boot_write(input logic [31:0] v);
      xfer(6'h28, {8'h15, v[7:0], v[15:8], v[23:16], v[31:24]}, 7'h00, 64'h0, 64'h0);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (sr1[0] !== 1'b0 && n < 400) begin
         @(negedge clock);
         n++;
      end
      check_reg({31'h0, sr1[0]}, 32'h0);
   endtask

   initial begin
      void'($urandom(29351));
      v2 = $urandom;
      repeat (8) @(negedge clock);
      resetn = 1'b1;
      xfer(6'h00, 40'h0, 7'h10, 64'h5A5B, 64'hFFFF);
      xfer(6'h00, 40'h0, 7'h08, 64'hFF, 64'hFF);
      op(8'h06);
      check_reg({31'h0, sr1[1]}, 32'h1);
      xfer(6'h09, {8'h04, 32'h0}, 7'h00, 64'h0, 64'h0);
      check_reg({31'h0, sr1[1]}, 32'h1);
      op(8'h04);
      check_reg({31'h0, sr1[1]}, 32'h0);
      op(8'h06);
      xfer(6'h10, {8'h01, 8'h80, 24'h0}, 7'h00, 64'h0, 64'h0);
      wait_idle();
      check_reg({24'h0, sr1}, 32'h80);
      write_protect_level = 1'b0;
      op(8'h06);
      xfer(6'h10, {8'h01, 8'h1C, 24'h0}, 7'h00, 64'h0, 64'h0);
      check_reg({24'h0, sr1}, 32'h82);
      write_protect_level = 1'b1;
      xfer(6'h10, {8'h01, 8'h1C, 24'h0}, 7'h00, 64'h0, 64'h0);
      wait_idle();
      check_reg({24'h0, sr1}, 32'h1C);
      op(8'hB9);
      xfer(6'h10, {8'h01, 8'h03, 24'h0}, 7'h00, 64'h0, 64'h0);
      check_reg({24'h0, bank, sr1}, 32'h031C);
      boot_write(v2);
      check_reg(boot_cfg, BOOT_INIT);
      op(8'h06);
      boot_write(v2);
      op(8'h04);
      check_reg({30'h0, sr1[1:0]}, 32'h3);
      wait_idle();
      check_reg({24'h0, sr1}, 32'h1C);
      check_reg(boot_cfg, v2);
      sw = {v2[7:0], v2[15:8], v2[23:16], v2[31:24]};
      xfer(6'h08, {8'h14, 32'h0}, 7'h40, {sw, sw}, {64{1'b1}});
      for (int k = 0; k < 2; k++) begin
         erase_fail = (k == 0);
         program_fail = (k == 1);
         op(8'h06);
         boot_write(~v2);
         wait_idle();
         erase_fail = 1'b0;
         program_fail = 1'b0;
         check_reg(boot_cfg, v2);
         check_reg({24'h0, sr1}, (k == 0) ? 32'h3C : 32'h5C);
         op(8'h30);
         check_reg({24'h0, sr1}, 32'h1C);
      end
      tally_and_finish();
   end
endmodule
